// ==== dspwm_map.vh ====
`ifndef DSPWM_MAP_VH
`define DSPWM_MAP_VH

// Register byte offsets
`define DSPWM_CTRL_OFS 8'h00
`define DSPWM_COUNT_OFS 8'h04
`define DSPWM_CMPA_OFS 8'h08
`define DSPWM_CMPB_OFS 8'h0c
`define DSPWM_CAPTOP_OFS 8'h10
`define DSPWM_FLAGS_OFS 8'h14

// Control register fields
`define DSPWM_WGM_LSB 0
`define DSPWM_CSEL_LSB 4
`define DSPWM_POLA_LSB 8
`define DSPWM_POLB_LSB 10
`define DSPWM_DIR_LSB 12
`define DSPWM_CTRL_RST 14'h0000

// Flag register fields
`define DSPWM_FLG_OVF 0
`define DSPWM_FLG_CMPA 1
`define DSPWM_FLG_CMPB 2
`define DSPWM_FLG_CAP 3

// Waveform mode codes
`define DSPWM_WGM_PC8 4'h1
`define DSPWM_WGM_PC9 4'h2
`define DSPWM_WGM_PC10 4'h3
`define DSPWM_WGM_PFC_CAP 4'h8
`define DSPWM_WGM_PFC_CMPA 4'h9
`define DSPWM_WGM_PC_CAP 4'ha
`define DSPWM_WGM_PC_CMPA 4'hb

// Fixed top values
`define DSPWM_TOP8 16'h00ff
`define DSPWM_TOP9 16'h01ff
`define DSPWM_TOP10 16'h03ff
`define DSPWM_MAX 16'hffff
`define DSPWM_BOTTOM 16'h0000

// Output polarity codes
`define DSPWM_POL_OFF 2'h0
`define DSPWM_POL_TOGGLE 2'h1
`define DSPWM_POL_NORM 2'h2
`define DSPWM_POL_INV 2'h3

// Clock select codes: divide by 1, 8, 64, 256, 1024
`define DSPWM_CS_DIV1 3'h1
`define DSPWM_CS_DIV8 3'h2
`define DSPWM_CS_DIV64 3'h3
`define DSPWM_CS_DIV256 3'h4
`define DSPWM_CS_DIV1024 3'h5

// Bus responses
`define DSPWM_RESP_OK 2'h0
`define DSPWM_RESP_ERR 2'h2

`endif

// ==== dspwm_prescale.v ====
`timescale 1ns/100ps
`include "dspwm_map.vh"

module dspwm_prescale #(
  parameter PW = 10
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Division select
  input wire [2:0] clk_sel,
  // Timer clock enable
  output reg tick
);

  reg [PW-1:0] div_q;

  // Free divider, parked while the timer is stopped
  always @(posedge aclk) begin
    if (!aresetn || clk_sel == 3'h0)
      div_q <= {PW{1'b0}};
    else
      div_q <= div_q + {{(PW-1){1'b0}}, 1'b1};
  end

  // One enable pulse per divided period
  always @* begin
    case (clk_sel)
      `DSPWM_CS_DIV1: tick = 1'b1;
      `DSPWM_CS_DIV8: tick = &div_q[2:0];
      `DSPWM_CS_DIV64: tick = &div_q[5:0];
      `DSPWM_CS_DIV256: tick = &div_q[7:0];
      `DSPWM_CS_DIV1024: tick = &div_q[9:0];
      default: tick = 1'b0;
    endcase
  end

endmodule // dspwm_prescale

// ==== dspwm_channel.v ====
`timescale 1ns/100ps
`include "dspwm_map.vh"

module dspwm_channel #(
  parameter CW = 16
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Buffer write and reload
  input wire wr_en,
  input wire [CW-1:0] wr_val,
  input wire load,
  // Counter view
  input wire tick,
  input wire [CW-1:0] count,
  input wire [CW-1:0] top,
  input wire eff_down,
  // Output control
  input wire [1:0] pol,
  input wire toggle_ok,
  // Results
  output reg [CW-1:0] buf_q,
  output reg [CW-1:0] cmp_q,
  output wire match,
  output reg wave_q
);

  // Buffered write, active value moves only on load
  always @(posedge aclk) begin
    if (!aresetn) begin
      buf_q <= {CW{1'b0}};
      cmp_q <= {CW{1'b0}};
    end else begin
      if (wr_en)
        buf_q <= wr_val;
      if (load)
        cmp_q <= buf_q;
    end
  end

  // No match while compare sits above top
  assign match = tick && count == cmp_q && cmp_q <= top;

  // Clear or set by slope, inverted by polarity
  always @(posedge aclk) begin
    if (!aresetn)
      wave_q <= 1'b0;
    else if (match) begin
      case (pol)
        `DSPWM_POL_NORM: wave_q <= eff_down;
        `DSPWM_POL_INV: wave_q <= ~eff_down;
        `DSPWM_POL_TOGGLE: wave_q <= wave_q ^ toggle_ok;
        default: wave_q <= wave_q;
      endcase
    end
  end

endmodule // dspwm_channel

// ==== dspwm_timer.v ====
`timescale 1ns/100ps
`include "dspwm_map.vh"

// Behaviour
// - Fixed tops 0x00FF/0x01FF/0x03FF for codes 1-3
// - Phase correct: 10 capture top, 11 compare A
// - Frequency correct: 8 capture top, 9 compare A
// - Count bottom up to top, then down
// - Top held one tick, then count down
// - Phase correct: overflow flag at bottom
// - Phase correct: reload and top flag at top
// - Frequency correct: reload and overflow at bottom
// - Frequency correct: top flag at top
// - Compare equal sets channel compare flag
// - Fixed top masks compare writes above resolution
// - Compare above top never matches
// - Polarity 2 normal, 3 inverted PWM
// - Normal: clear matching up, set matching down
// - Waveform reaches pin only when direction output
// - Normal: compare at bottom low, at top high
// - Tick at clock divided 1/8/64/256/1024
// - Compare A writes go through buffer
// - Capture top unbuffered, takes effect immediately
module dspwm_timer #(
  parameter CW = 16,
  parameter AW = 8,
  parameter PW = 10
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write address channel
  input wire [AW-1:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output wire awready,
  // Write data channel
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  // Write response channel
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // Read address channel
  input wire [AW-1:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output wire arready,
  // Read data channel
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Port logic behind the pins
  input wire [1:0] port_data,
  // Compare output pins
  output wire [1:0] pin_o,
  output wire [1:0] pin_oe_n,
  // Raw waveforms and tick
  output wire [1:0] channel_wave_output,
  output wire compare_a_output,
  output wire timer_tick
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  reg [13:0] ctrl_q;
  reg [CW-1:0] count_value_q;
  reg down_q;
  reg [CW-1:0] capture_top_value_q;
  reg [3:0] flags_q;
  reg aw_hold_q;
  reg [AW-1:0] awaddr_q;
  reg w_hold_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [CW-1:0] top;
  reg [CW-1:0] res_mask;
  reg dual;
  reg pfc;
  reg cap_top;
  reg cmpa_top;
  reg [31:0] rd_d;
  reg rd_err;
  reg wr_err;
  reg [3:0] flag_set;
  wire [3:0] waveform_mode_code;
  wire [2:0] clk_sel;
  wire [1:0] pin_direction_bit;
  wire [3:0] output_polarity_mode;
  wire tick;
  wire do_wr;
  wire [AW-1:0] wa;
  wire [AW-1:0] ra;
  wire wr_ctrl;
  wire wr_count;
  wire wr_cap;
  wire wr_flags;
  wire [1:0] wr_cmp;
  wire [2*CW-1:0] buf_all;
  wire [2*CW-1:0] cmp_all;
  wire [1:0] match;
  wire [CW-1:0] compare_a_value;
  wire at_top;
  wire at_bot;
  wire load;
  wire eff_down;
  wire [3:0] overflow_clr;
  wire [15:0] ctrl_new;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge a 16-bit register with byte strobes
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0] strb;
    begin
      merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Control fields

  assign waveform_mode_code = ctrl_q[`DSPWM_WGM_LSB +: 4];
  assign clk_sel = ctrl_q[`DSPWM_CSEL_LSB +: 3];
  assign output_polarity_mode = {ctrl_q[`DSPWM_POLB_LSB +: 2],
                                 ctrl_q[`DSPWM_POLA_LSB +: 2]};
  assign pin_direction_bit = ctrl_q[`DSPWM_DIR_LSB +: 2];
  assign ctrl_new = merge16({2'b00, ctrl_q}, wdata_q[15:0], wstrb_q[1:0]);

  ////////////////////////////////////////////////////////////////////////
  // Timer clock enable

  // Divided enable for the whole timer
  dspwm_prescale #(
    .PW(PW)
  ) u_prescale (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_sel(clk_sel),
    .tick(tick)
  );

  assign timer_tick = tick;

  ////////////////////////////////////////////////////////////////////////
  // Top selection

  // Top source and resolution mask per mode
  always @* begin
    dual = 1'b1;
    pfc = 1'b0;
    cap_top = 1'b0;
    cmpa_top = 1'b0;
    res_mask = `DSPWM_MAX;
    top = `DSPWM_MAX;
    case (waveform_mode_code)
      `DSPWM_WGM_PC8: begin
        top = `DSPWM_TOP8;
        res_mask = `DSPWM_TOP8;
      end
      `DSPWM_WGM_PC9: begin
        top = `DSPWM_TOP9;
        res_mask = `DSPWM_TOP9;
      end
      `DSPWM_WGM_PC10: begin
        top = `DSPWM_TOP10;
        res_mask = `DSPWM_TOP10;
      end
      `DSPWM_WGM_PC_CAP: begin
        top = capture_top_value_q;
        cap_top = 1'b1;
      end
      `DSPWM_WGM_PC_CMPA: begin
        top = compare_a_value;
        cmpa_top = 1'b1;
      end
      `DSPWM_WGM_PFC_CAP: begin
        top = capture_top_value_q;
        cap_top = 1'b1;
        pfc = 1'b1;
      end
      `DSPWM_WGM_PFC_CMPA: begin
        top = compare_a_value;
        cmpa_top = 1'b1;
        pfc = 1'b1;
      end
      default: dual = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Dual-slope counter

  // Turning points seen on a tick
  assign at_top = tick && dual && !down_q && count_value_q == top;
  assign at_bot = tick && dual && count_value_q == `DSPWM_BOTTOM;

  // Slope seen by the compare units; top counts as falling
  assign eff_down = (count_value_q == top) ? 1'b1 :
                    (count_value_q == `DSPWM_BOTTOM) ? 1'b0 : down_q;

  // Up to top, one tick there, then down to bottom
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_value_q <= `DSPWM_BOTTOM;
      down_q <= 1'b0;
    end else if (wr_count) begin
      count_value_q <= merge16(count_value_q, wdata_q[15:0],
                               wstrb_q[1:0]);
    end else if (tick && dual) begin
      if (!down_q) begin
        if (count_value_q == top) begin
          down_q <= 1'b1;
          count_value_q <= count_value_q - 16'h0001;
        end else begin
          count_value_q <= count_value_q + 16'h0001;
        end
      end else if (count_value_q == `DSPWM_BOTTOM) begin
        down_q <= 1'b0;
        count_value_q <= 16'h0001;
      end else begin
        count_value_q <= count_value_q - 16'h0001;
      end
    end
  end

  // Reload point: top for phase, bottom for frequency correct
  assign load = dual ? (pfc ? at_bot : at_top) : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Compare channels

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      // One compare unit per output channel
      dspwm_channel #(
        .CW(CW)
      ) u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_cmp[g]),
        .wr_val(merge16(buf_all[g*CW +: CW], wdata_q[15:0],
                        wstrb_q[1:0]) & res_mask),
        .load(load),
        .tick(tick),
        .count(count_value_q),
        .top(top),
        .eff_down(eff_down),
        .pol(output_polarity_mode[2*g +: 2]),
        .toggle_ok(g == 0 && waveform_mode_code[3]),
        .buf_q(buf_all[g*CW +: CW]),
        .cmp_q(cmp_all[g*CW +: CW]),
        .match(match[g]),
        .wave_q(channel_wave_output[g])
      );
      // Pin follows waveform unless polarity is off; enable from direction
      assign pin_o[g] = (output_polarity_mode[2*g +: 2] !=
                         `DSPWM_POL_OFF) ? channel_wave_output[g]
                        : port_data[g];
      assign pin_oe_n[g] = ~pin_direction_bit[g];
    end
  endgenerate

  assign compare_a_value = cmp_all[CW-1:0];
  assign compare_a_output = channel_wave_output[0];

  ////////////////////////////////////////////////////////////////////////
  // Status flags

  // Events raising each flag
  always @* begin
    flag_set = 4'h0;
    flag_set[`DSPWM_FLG_OVF] = at_bot;
    flag_set[`DSPWM_FLG_CMPA] = match[0]
                               || (at_top && cmpa_top);
    flag_set[`DSPWM_FLG_CMPB] = match[1];
    flag_set[`DSPWM_FLG_CAP] = at_top && cap_top;
  end

  assign overflow_clr = wr_flags && wstrb_q[0] ? wdata_q[3:0] : 4'h0;

  // Write one to clear; a new event wins over the clear
  always @(posedge aclk) begin
    if (!aresetn)
      flags_q <= 4'h0;
    else
      flags_q <= (flags_q & ~overflow_clr) | flag_set;
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  assign awready = !aw_hold_q && !bvalid;
  assign wready = !w_hold_q && !bvalid;
  assign do_wr = aw_hold_q && w_hold_q;
  assign wa = {awaddr_q[AW-1:2], 2'b00};

  assign wr_ctrl = do_wr && wa == `DSPWM_CTRL_OFS;
  assign wr_count = do_wr && wa == `DSPWM_COUNT_OFS;
  assign wr_cmp[0] = do_wr && wa == `DSPWM_CMPA_OFS;
  assign wr_cmp[1] = do_wr && wa == `DSPWM_CMPB_OFS;
  assign wr_cap = do_wr && wa == `DSPWM_CAPTOP_OFS;
  assign wr_flags = do_wr && wa == `DSPWM_FLAGS_OFS;

  // Unmapped write address
  always @* begin
    wr_err = !(wr_ctrl || wr_count || wr_cmp[0] || wr_cmp[1] ||
               wr_cap || wr_flags);
  end

  // Take address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= {AW{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= awaddr;
      end else if (do_wr) begin
        aw_hold_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (do_wr) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // Write response one cycle after both halves are held
  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `DSPWM_RESP_OK;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp <= wr_err ? `DSPWM_RESP_ERR : `DSPWM_RESP_OK;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control and capture top registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `DSPWM_CTRL_RST;
      capture_top_value_q <= `DSPWM_BOTTOM;
    end else begin
      if (wr_ctrl)
        ctrl_q <= ctrl_new[13:0];
      if (wr_cap)
        capture_top_value_q <= merge16(capture_top_value_q,
                                       wdata_q[15:0],
                                       wstrb_q[1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  assign arready = !rvalid;
  assign ra = {araddr[AW-1:2], 2'b00};

  // Read data selection
  always @* begin
    rd_d = 32'h00000000;
    rd_err = 1'b0;
    case (ra)
      `DSPWM_CTRL_OFS: rd_d = {18'h00000, ctrl_q};
      `DSPWM_COUNT_OFS: rd_d = {16'h0000, count_value_q};
      `DSPWM_CMPA_OFS: rd_d = {16'h0000, buf_all[CW-1:0]};
      `DSPWM_CMPB_OFS: rd_d = {16'h0000, buf_all[2*CW-1:CW]};
      `DSPWM_CAPTOP_OFS: rd_d = {16'h0000, capture_top_value_q};
      `DSPWM_FLAGS_OFS: rd_d = {27'h0000000, down_q, flags_q};
      default: rd_err = 1'b1;
    endcase
  end

  // Read answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `DSPWM_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_d;
      rresp <= rd_err ? `DSPWM_RESP_ERR : `DSPWM_RESP_OK;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // dspwm_timer

// ==== dspwm_timer_sva.sv ====
`timescale 1ns/100ps
// Handshake and waveform timing checks on the timer ports
module dspwm_chk (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire awready,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire rvalid,
  input wire rready,
  // Timer side
  input wire timer_tick,
  input wire [1:0] channel_wave_output,
  input wire compare_a_output
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  wave_on_tick_a: assert property (
    $changed(channel_wave_output) |-> $past(timer_tick))
    else $error("waveform moved without a tick");
  out_a_copy_a: assert property (
    compare_a_output == channel_wave_output[0])
    else $error("channel a output differs from its waveform");
  b_rise_a: assert property (
    $rose(bvalid) |-> $past(!awready && !wready))
    else $error("write response before both halves taken");
  b_drop_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response stayed after acceptance");
  w_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  ar_gate_a: assert property (arready == !rvalid)
    else $error("read address ready wrong");
  r_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  r_rise_a: assert property (
    $rose(rvalid) |-> $past(arvalid && arready))
    else $error("read data without a request");
endmodule // dspwm_chk

// ==== dspwm_load.sv ====
`timescale 1ns/100ps
// External load on the compare pins; pull-ups hold undriven lines
module dspwm_load (
  // Pin side
  input wire [1:0] pin_o,
  input wire [1:0] pin_oe_n,
  // Line level seen by the load
  output wire [1:0] line
);
  // Driven only while the enable is low, else pulled high
  assign line = (pin_o & ~pin_oe_n) | pin_oe_n;
endmodule // dspwm_load

// ==== dspwm_timer_bench.sv ====
`timescale 1ns/100ps
`include "dspwm_map.vh"
module dspwm_timer_bench;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h0, araddr = 8'h0;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [1:0] port_data = 2'h0;
  wire awready, wready, bvalid, arready, rvalid, tick, a_out;
  wire [1:0] bresp, rresp, pin_o, pin_oe_n, wave, line;
  wire [31:0] rdata;
  integer failures = 0, samples_checked = 0;
  // Reference state
  reg [3:0] m_mode = 0, flg = 0;
  reg [1:0] m_pa = 0, m_pb = 0, m_dir = 0, wm = 0;
  reg [15:0] cnt = 0, cap = 0, ba = 0, bb = 0, aa = 0, ab = 0;
  reg dn = 0, chk_on = 0;
  dspwm_timer dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'h3), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .port_data(port_data),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .channel_wave_output(wave),
    .compare_a_output(a_out), .timer_tick(tick));
  dspwm_load load (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .line(line));
  always #5 aclk = ~aclk;
  always @(posedge aclk) port_data <= 2'($urandom);
  ////////////////////////////////////////
  function [15:0] top_of(input [3:0] m);
    case (m)
      4'h1: top_of = `DSPWM_TOP8;
      4'h2: top_of = `DSPWM_TOP9;
      4'h3: top_of = `DSPWM_TOP10;
      4'h8, 4'ha: top_of = cap;
      default: top_of = aa;
    endcase
  endfunction
  // Fixed tops cut compare writes; other modes keep all bits
  function [15:0] mask_of(input [3:0] m);
    mask_of = (m >= 4'h1 && m <= 4'h3) ? top_of(m) : 16'hffff;
  endfunction
  function dual(input [3:0] m);
    dual = (m >= 4'h1 && m <= 4'h3) || m >= 4'h8;
  endfunction
  // Bottom, top or anything between, as software may pick
  function [15:0] pick(input [15:0] t);
    integer r;
    begin
      r = $urandom % 4;
      pick = (r == 0) ? 16'h0 : (r == 1) ? t : 16'($urandom % (t + 1));
    end
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task bound(input ok);
    if (!ok) begin
      failures = failures + 1;
      stop_test;
    end
  endtask
  // Mirror a register write at the edge that completes it
  task shadow(input [7:0] a, input [31:0] d);
    case (a)
      `DSPWM_CTRL_OFS: {m_dir, m_pb, m_pa, m_mode} <= {d[13:8], d[3:0]};
      `DSPWM_COUNT_OFS: cnt <= d[15:0];
      `DSPWM_CMPA_OFS: ba <= d[15:0] & mask_of(m_mode);
      `DSPWM_CMPB_OFS: bb <= d[15:0] & mask_of(m_mode);
      `DSPWM_CAPTOP_OFS: cap <= d[15:0];
      `DSPWM_FLAGS_OFS: flg <= flg & ~d[3:0];
      default: ;
    endcase
  endtask
  ////////////////////////////////////////
  task wr(input [7:0] a, input [31:0] d);
    integer n;
    reg ta, tw, done, sh;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      {ta, tw, done, sh} = 4'h0;
      for (n = 0; n < 60 && !done; n = n + 1) begin
        @(posedge aclk);
        // Register lands one edge after both halves are taken
        if (sh) begin
          shadow(a, d);
          sh = 1'b0;
        end
        if (bvalid) begin
          done = 1'b1;
          bready <= 1'b0;
          check(bresp, a > 8'h14 ? 2'h2 : 2'h0);
        end
        if (!ta && awready) begin
          ta = 1'b1;
          awvalid <= 1'b0;
          if (tw) sh = 1'b1;
        end
        if (!tw && wready) begin
          tw = 1'b1;
          wvalid <= 1'b0;
          if (ta) sh = 1'b1;
        end
      end
      bound(done);
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    integer n;
    reg done;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      d = 32'h0;
      for (n = 0; n < 60 && !done; n = n + 1) begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) begin
          done = 1'b1;
          d = rdata;
          rready <= 1'b0;
          check(rresp, a > 8'h14 ? 2'h2 : 2'h0);
        end
      end
      bound(done);
    end
  endtask
  ////////////////////////////////////////
  // Reference counter, compare units, flags and waveforms
  always @(posedge aclk) begin : ref_model
    reg [15:0] t;
    reg ed;
    t = top_of(m_mode);
    ed = (cnt == t) || (cnt != 16'h0 && dn);
    if (!aresetn) begin
      {cnt, dn, flg, wm} <= 23'h0;
    end else if (!dual(m_mode)) begin
      aa <= ba;
      ab <= bb;
    end else if (tick) begin
      cnt <= ed ? cnt - 16'h1 : cnt + 16'h1;
      dn <= ed;
      if (cnt == 16'h0) flg[0] <= 1'b1;
      if (cnt == (m_mode[3] && !m_mode[1] ? 16'h0 : t)) begin
        aa <= ba;
        ab <= bb;
      end
      if (cnt == t && m_mode[3] && !m_mode[0]) flg[3] <= 1'b1;
      if (cnt == aa) flg[1] <= 1'b1;
      if (cnt == ab) flg[2] <= 1'b1;
      if (cnt == aa && m_pa[1]) wm[0] <= ed ^ m_pa[0];
      if (cnt == ab && m_pb[1]) wm[1] <= ed ^ m_pb[0];
      // Toggle on channel A only in the register-top modes
      if (cnt == aa && m_pa == 2'h1 && m_mode[3]) wm[0] <= !wm[0];
    end
  end
  // Waveform and pin levels compared on the falling edge
  always @(negedge aclk) begin : pin_view
    reg [1:0] ep;
    ep[0] = (m_pa == 2'h0) ? port_data[0] : wm[0];
    ep[1] = (m_pb == 2'h0) ? port_data[1] : wm[1];
    if (chk_on) begin
      check(wave, wm);
      check(a_out, wm[0]);
      check(pin_oe_n, {~m_dir});
      check(pin_o, ep);
      check(line, {(ep & m_dir) | ~m_dir});
    end
  end
  // Stop the timer, compare counter and flags, then clear both
  task settle;
    reg [31:0] d;
    begin
      chk_on = 1'b0;
      wr(`DSPWM_CTRL_OFS, 32'h0);
      repeat (3) @(posedge aclk);
      rd(`DSPWM_FLAGS_OFS, d);
      check(d[3:0], flg);
      rd(`DSPWM_COUNT_OFS, d);
      check(d[15:0], cnt);
      wr(`DSPWM_FLAGS_OFS, 32'hf);
      wr(`DSPWM_COUNT_OFS, 32'h0);
    end
  endtask
  ////////////////////////////////////////
  initial begin : main
    integer i, k, n, gap;
    reg [31:0] d, ctl;
    reg [15:0] t;
    reg [3:0] md;
    k = $urandom(32'hec56);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // Unmapped place answers with an error and reads zero
    wr(8'h18, 32'h1);
    rd(8'h18, d);
    check(d, 32'h0);
    // Fixed tops cut compare writes to their resolution
    for (k = 1; k < 4; k = k + 1) begin
      wr(`DSPWM_CTRL_OFS, k);
      wr(`DSPWM_CMPA_OFS, 32'hffff);
      rd(`DSPWM_CMPA_OFS, d);
      check(d, top_of(k[3:0]));
    end
    // Tick spacing for every divider
    for (k = 1; k < 6; k = k + 1) begin
      wr(`DSPWM_CTRL_OFS, 32'ha01 | (k << 4));
      {gap, n} = 0;
      while (n < 2 && gap < 3000) begin
        @(posedge aclk);
        gap = gap + 1;
        if (tick) begin
          if (n == 0) gap = 0;
          n = n + 1;
        end
      end
      bound(n == 2);
      check(gap, k < 4 ? 1 << (3 * k - 3) : k == 4 ? 256 : 1024);
    end
    // Random runs over every dual-slope mode
    for (i = 0; i < 14; i = i + 1) begin
      settle;
      k = (i < 7) ? i : $urandom % 7;
      md = k[3:0] + ((k < 3) ? 4'h1 : 4'h5);
      t = (md < 4) ? top_of(md) : 16'h3 + 16'($urandom % 40);
      wr(`DSPWM_CAPTOP_OFS, {16'h0, t});
      wr(`DSPWM_CMPA_OFS, {16'h0, md[0] && md[3] ? t : pick(t)});
      wr(`DSPWM_CMPB_OFS, {16'h0, pick(t)});
      ctl = {18'h0, 2'($urandom), 4'($urandom), 4'h0, md};
      wr(`DSPWM_CTRL_OFS, ctl);
      t = ($urandom % 4 == 0 && md[3] && !md[0]) ? t + 16'h2 : pick(t);
      wr(`DSPWM_CMPB_OFS, {16'h0, t});
      wr(`DSPWM_CTRL_OFS, ctl | 32'h10);
      chk_on = 1'b1;
      repeat (300 + $urandom % 2200) @(posedge aclk);
    end
    settle;
    stop_test;
  end
endmodule // dspwm_timer_bench
bind dspwm_timer dspwm_chk chk (.aclk(aclk), .aresetn(aresetn),
  .awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .timer_tick(timer_tick),
  .channel_wave_output(channel_wave_output),
  .compare_a_output(compare_a_output));
